// ---- logic/smc_config_regs.sv ----
// Synthesizer and modem configuration register bank with decoded outputs.
`timescale 1ns/1ps

module smc_config_regs (
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        reset,
  // Register port, same clock domain.
  input  wire logic        regWrite,
  input  wire logic        regRead,
  input  wire logic [5:0]  regAddr,
  input  wire logic [7:0]  regWriteData,
  output logic      [7:0]  regReadData,
  output logic             regReadValid,
  // Synthesizer controls.
  output logic      [4:0]  intermediateOffsetWord,
  output logic      [4:0]  mixerOffsetWord,
  output logic      [7:0]  signedSynthOffset,
  output logic      [23:0] carrierBaseWord,
  output logic      [23:0] synthFrequencyWord,
  // Modem controls.
  output logic      [1:0]  bandwidthExponent,
  output logic      [1:0]  bandwidthMantissa,
  output logic      [5:0]  decimationRatio,
  output logic      [3:0]  symbolRateExponent,
  output logic      [8:0]  symbolRateMantissa,
  output logic      [23:0] symbolRateTerm,
  // Receive state from the radio core.
  input  wire logic        rxActive
);

  // Everything the bank remembers lives in one packed struct, so that the reset
  // branch and the register copy touch one object and nothing can be forgotten.
  typedef struct packed {
    // Stored register bytes as the host wrote them, already masked on the way in.
    logic [7:0]  synthIfControl;
    logic [7:0]  synthOffsetControl;
    logic [7:0]  carrierWordHigh;
    logic [7:0]  carrierWordMiddle;
    logic [7:0]  carrierWordLow;
    logic [7:0]  bandwidthRateExponent;
    logic [7:0]  rateMantissa;
    // Read port answer; the data holds until the next read, valid is a pulse.
    logic [7:0]  readData;
    logic        readValid;
    // Decoded synthesizer controls, one cycle behind the stored bytes.
    logic [4:0]  ifWord;
    logic [4:0]  mixerWord;
    logic [23:0] baseWord;
    logic [23:0] synthWord;
    // Decoded modem controls, also one cycle behind the stored bytes.
    logic [5:0]  decimation;
    logic [8:0]  rateMant;
    logic [23:0] rateTerm;
  } smc_state_t;

  smc_state_t state;
  smc_state_t next_state;

  // The write mask is the single place that decides which bits a host can change.
  // Bits outside the mask are never stored, so the read path needs no mask of its
  // own and a read-only bit cannot come back as one even after a write of all ones.
  // Keeping the mask and the read mux apart costs a little logic, but it means a
  // new read-only bit is added in one place only.
  // Unmapped addresses get an empty mask, so a stray write changes nothing at all.
  // Writable mask per address; unmapped addresses write nothing.
  function automatic logic [7:0] smc_write_mask(input logic [5:0] addr);
    unique case (addr)
      smc_pkg::ADDR_SYNTH_IF_CONTROL:  smc_write_mask = smc_pkg::MASK_SYNTH_IF_CONTROL;
      smc_pkg::ADDR_CARRIER_WORD_HIGH: smc_write_mask = smc_pkg::MASK_CARRIER_WORD_HIGH;
      smc_pkg::ADDR_SYNTH_OFFSET_CONTROL, smc_pkg::ADDR_CARRIER_WORD_MIDDLE,
      smc_pkg::ADDR_CARRIER_WORD_LOW, smc_pkg::ADDR_BANDWIDTH_RATE_EXPONENT,
      smc_pkg::ADDR_RATE_MANTISSA:     smc_write_mask = smc_pkg::MASK_FULL;
      default:                         smc_write_mask = 8'h00;
    endcase
  endfunction

  // The next state is worked out in three steps.
  // First, a write strobe stores its masked byte into the addressed register.
  // Second, a read strobe copies the addressed register into the read holder.
  // A write and a read to the same address in one cycle therefore return the old
  // value, because the read looks at the current state, not at the next one.
  // Third, the decoded controls are rebuilt from the current stored bytes.
  // The decoded values thus lag a write by one cycle; the radio core sees a clean
  // registered word and never a half-updated mix of old and new bytes within a cycle.
  // A limitation for software: the carrier word is three separate bytes, so between
  // the writes of the high, middle and low bytes the synthesizer sees mixed words.
  // Software that retunes during reception should therefore leave receive first.
  // Register update, read mux and decoded values in one combinational pass.
  always_comb begin
    logic [7:0]  wdata;
    logic [23:0] base;
    logic [23:0] offs;
    logic [8:0]  mant;
    wdata = 8'h00;
    base = 24'h000000;
    offs = 24'h000000;
    mant = 9'h000;
    next_state = state;
    wdata = regWriteData & smc_write_mask(regAddr);
    if (regWrite) begin
      unique case (regAddr)
        smc_pkg::ADDR_SYNTH_IF_CONTROL:        next_state.synthIfControl = wdata;
        smc_pkg::ADDR_SYNTH_OFFSET_CONTROL:    next_state.synthOffsetControl = wdata;
        smc_pkg::ADDR_CARRIER_WORD_HIGH:       next_state.carrierWordHigh = wdata;
        smc_pkg::ADDR_CARRIER_WORD_MIDDLE:     next_state.carrierWordMiddle = wdata;
        smc_pkg::ADDR_CARRIER_WORD_LOW:        next_state.carrierWordLow = wdata;
        smc_pkg::ADDR_BANDWIDTH_RATE_EXPONENT: next_state.bandwidthRateExponent = wdata;
        smc_pkg::ADDR_RATE_MANTISSA:           next_state.rateMantissa = wdata;
        default:                               next_state.readValid = state.readValid;
      endcase
    end
    // Reads return stored bits only, so masked bits always read zero.
    next_state.readValid = regRead;
    if (regRead) begin
      unique case (regAddr)
        smc_pkg::ADDR_SYNTH_IF_CONTROL:        next_state.readData = state.synthIfControl;
        smc_pkg::ADDR_SYNTH_OFFSET_CONTROL:    next_state.readData = state.synthOffsetControl;
        smc_pkg::ADDR_CARRIER_WORD_HIGH:       next_state.readData = state.carrierWordHigh;
        smc_pkg::ADDR_CARRIER_WORD_MIDDLE:     next_state.readData = state.carrierWordMiddle;
        smc_pkg::ADDR_CARRIER_WORD_LOW:        next_state.readData = state.carrierWordLow;
        smc_pkg::ADDR_BANDWIDTH_RATE_EXPONENT: next_state.readData = state.bandwidthRateExponent;
        smc_pkg::ADDR_RATE_MANTISSA:           next_state.readData = state.rateMantissa;
        default:                               next_state.readData = 8'h00;
      endcase
    end
    // The carrier word is simply the three bytes side by side; the two top bits
    // are zero because the high byte can never store them.
    // The offset byte is sign-extended so that negative offsets wrap correctly
    // in the 24-bit sum, which is taken modulo two to the 24.
    // Decoded values follow the stored registers one cycle later.
    base = {state.carrierWordHigh, state.carrierWordMiddle, state.carrierWordLow};
    offs = {{16{state.synthOffsetControl[7]}}, state.synthOffsetControl};
    next_state.ifWord = state.synthIfControl[4:0];
    next_state.mixerWord = state.synthIfControl[4:0];
    next_state.baseWord = base;
    // In receive the IF word is subtracted from the base; offset always applies.
    if (rxActive) begin
      next_state.synthWord = base + offs - {19'h00000, state.synthIfControl[4:0]};
    end else begin
      next_state.synthWord = base + offs;
    end
    // The bandwidth divider is small: at most seven shifted by three, which fits
    // the six-bit output, so no bits are lost in the shift.
    // Decimation is (4 + mantissa) << exponent; the fixed factor 8 stays analog.
    next_state.decimation = {3'h0, smc_pkg::BW_MANT_BASE + {1'b0,
                             state.bandwidthRateExponent[5:4]}}
                            << state.bandwidthRateExponent[7:6];
    // The stored mantissa gains its hidden leading one, giving nine bits; the
    // largest term, nine ones shifted by fifteen, still fits in 24 bits.
    // The final division by two to the 28 is left to the rate generator.
    mant = smc_pkg::RATE_HIDDEN_ONE | {1'b0, state.rateMantissa};
    next_state.rateMant = mant;
    next_state.rateTerm = {15'h0000, mant} << state.bandwidthRateExponent[3:0];
  end

  // The reset is synchronous, so the bank must see at least one clock edge with
  // reset high before its contents are valid.
  // Decoded outputs read zero during reset and take their decoded default values
  // at the first edge after release, one cycle behind the stored registers.
  // Single state register; synchronous reset loads the register defaults and clears the rest.
  always_ff @(posedge mclk) begin
    if (reset) begin
      state <= '0;
      state.synthIfControl <= smc_pkg::RST_SYNTH_IF_CONTROL;
      state.synthOffsetControl <= smc_pkg::RST_SYNTH_OFFSET_CONTROL;
      state.carrierWordHigh <= smc_pkg::RST_CARRIER_WORD_HIGH;
      state.carrierWordMiddle <= smc_pkg::RST_CARRIER_WORD_MIDDLE;
      state.carrierWordLow <= smc_pkg::RST_CARRIER_WORD_LOW;
      state.bandwidthRateExponent <= smc_pkg::RST_BANDWIDTH_RATE_EXPONENT;
      state.rateMantissa <= smc_pkg::RST_RATE_MANTISSA;
    end else begin
      state <= next_state;
    end
  end

  // Every output is a plain wire from a state flip-flop, so no output has a
  // combinational path from any input and timing at the ports is simple.
  // The raw register fields are shown immediately, while the decoded words come
  // from their own flip-flops and trail by one cycle.
  // Outputs come straight from the state register.
  assign regReadData            = state.readData;
  assign regReadValid           = state.readValid;
  assign intermediateOffsetWord = state.ifWord;
  assign mixerOffsetWord        = state.mixerWord;
  assign signedSynthOffset      = state.synthOffsetControl;
  assign carrierBaseWord        = state.baseWord;
  assign synthFrequencyWord     = state.synthWord;
  assign bandwidthExponent      = state.bandwidthRateExponent[7:6];
  assign bandwidthMantissa      = state.bandwidthRateExponent[5:4];
  assign decimationRatio        = state.decimation;
  assign symbolRateExponent     = state.bandwidthRateExponent[3:0];
  assign symbolRateMantissa     = state.rateMant;
  assign symbolRateTerm         = state.rateTerm;

endmodule

// ---- logic/smc_pkg.sv ----
// Package with register offsets, field layouts and reset values of the synthesizer/modem bank.
package smc_pkg;
  // Register offsets on the configuration port.
  localparam logic [5:0] ADDR_SYNTH_IF_CONTROL        = 6'h0B;
  localparam logic [5:0] ADDR_SYNTH_OFFSET_CONTROL    = 6'h0C;
  localparam logic [5:0] ADDR_CARRIER_WORD_HIGH       = 6'h0D;
  localparam logic [5:0] ADDR_CARRIER_WORD_MIDDLE     = 6'h0E;
  localparam logic [5:0] ADDR_CARRIER_WORD_LOW        = 6'h0F;
  localparam logic [5:0] ADDR_BANDWIDTH_RATE_EXPONENT = 6'h10;
  localparam logic [5:0] ADDR_RATE_MANTISSA           = 6'h11;
  // Reset values.
  localparam logic [7:0] RST_SYNTH_IF_CONTROL        = 8'h0F;
  localparam logic [7:0] RST_SYNTH_OFFSET_CONTROL    = 8'h00;
  localparam logic [7:0] RST_CARRIER_WORD_HIGH       = 8'h1E;
  localparam logic [7:0] RST_CARRIER_WORD_MIDDLE     = 8'hC4;
  localparam logic [7:0] RST_CARRIER_WORD_LOW        = 8'hEC;
  localparam logic [7:0] RST_BANDWIDTH_RATE_EXPONENT = 8'h8C;
  localparam logic [7:0] RST_RATE_MANTISSA           = 8'h22;
  // Writable bit masks; bits outside a mask read as zero.
  localparam logic [7:0] MASK_SYNTH_IF_CONTROL  = 8'h3F;
  localparam logic [7:0] MASK_CARRIER_WORD_HIGH = 8'h3F;
  localparam logic [7:0] MASK_FULL              = 8'hFF;
  // Implicit leading one of the symbol rate mantissa.
  localparam logic [8:0] RATE_HIDDEN_ONE = 9'h100;
  // Base term of the bandwidth divider (4 plus mantissa).
  localparam logic [2:0] BW_MANT_BASE = 3'h4;
endpackage

// ---- verification/smc_config_regs_asserts.sv ----
// Concurrent checks on the ports of the synthesizer/modem register bank.
`timescale 1ns/1ps
module smc_config_regs_asserts (
  // Clock, reset, register port, receive state and the raw offset byte.
  input wire logic        mclk, reset, regRead, regWrite, regReadValid, rxActive,
  input wire logic [5:0]  regAddr,
  input wire logic [7:0]  regReadData, signedSynthOffset,
  // Decoded controls and the raw symbol rate exponent.
  input wire logic [4:0]  intermediateOffsetWord, mixerOffsetWord,
  input wire logic [23:0] carrierBaseWord, synthFrequencyWord, symbolRateTerm,
  input wire logic [3:0]  symbolRateExponent,
  input wire logic [8:0]  symbolRateMantissa
);
  // Decoded outputs lag one edge, so the checks that look back with $past skip the edge just after reset.
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  property p_valid; regRead |=> regReadValid; endproperty
  a_valid: assert property (p_valid) else $error("read not answered");
  property p_quiet; !regRead |=> !regReadValid; endproperty
  a_quiet: assert property (p_quiet) else $error("stray read valid");
  property p_mixer; intermediateOffsetWord == mixerOffsetWord; endproperty
  a_mixer: assert property (p_mixer) else $error("mixer word differs");
  property p_top; regRead && regAddr == 6'h0D |=> regReadData[7:6] == 2'h0; endproperty
  a_top: assert property (p_top) else $error("carrier top bits set");
  property p_unmapped; regRead && (regAddr < 6'h0B || regAddr > 6'h11) |=> regReadData == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_hidden; !$past(reset) |-> symbolRateMantissa[8]; endproperty
  a_hidden: assert property (p_hidden) else $error("hidden one missing");
  property p_term; !$past(reset) |->
    symbolRateTerm == 24'(symbolRateMantissa) << $past(symbolRateExponent); endproperty
  a_term: assert property (p_term) else $error("rate term wrong");
  property p_synth; !$past(reset) |-> synthFrequencyWord == 24'(carrierBaseWord
    + 24'($signed($past(signedSynthOffset))) - ($past(rxActive) ? intermediateOffsetWord : 5'h00));
  endproperty
  a_synth: assert property (p_synth) else $error("synth word wrong");
  c_rxwrite: cover property (regWrite && rxActive);
  c_valid: cover property (regReadValid);
  c_high: cover property (regRead && regAddr == 6'h0D);
endmodule

// ---- verification/smc_host_model.sv ----
// Host controller model issuing strobes on the configuration port.
`timescale 1ns/1ps
module smc_host_model (
  // Clock and answers from the bank.
  input  wire logic       mclk,
  input  wire logic [7:0] regReadData,
  input  wire logic       regReadValid,
  // Strobes towards the bank.
  output logic            regWrite = 1'b0,
  output logic            regRead = 1'b0,
  output logic      [5:0] regAddr = 6'h3F,
  output logic      [7:0] regWriteData = 8'h00
);
  // One write; address and data are inverted afterwards so stale values never look valid.
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge mclk);
    regWrite = 1'b1;
    regAddr = a;
    regWriteData = d;
    @(negedge mclk);
    regWrite = 1'b0;
    regAddr = ~a;
    regWriteData = ~d;
  endtask
  // One read; the answer is taken in the cycle after the capture edge, while valid stands.
  task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic v);
    @(negedge mclk);
    regRead = 1'b1;
    regAddr = a;
    @(negedge mclk);
    d = regReadData;
    v = regReadValid;
    regRead = 1'b0;
    regAddr = ~a;
  endtask
endmodule

// ---- verification/tb_top.sv ----
// Self-checking bench for the synthesizer/modem register bank.
`timescale 1ns/1ps
module tb_top;
  logic mclk = 1'b0, reset = 1'b1, rxActive = 1'b0, regWrite, regRead, regReadValid, vld;
  logic [5:0] regAddr, dec;
  logic [7:0] regWriteData, regReadData, rdat, sso;
  logic [4:0] iow, mow;
  logic [1:0] bwe, bwm;
  logic [23:0] cbw, sfw, srt;
  logic [3:0] sre;
  logic [8:0] srm;
  int fails = 0, checked = 0, cycles = 0;
  always #20 mclk = ~mclk;
  smc_host_model smc_host_model_i (.mclk, .regReadData, .regReadValid, .regWrite, .regRead,
    .regAddr, .regWriteData);
  smc_config_regs smc_config_regs_i (.mclk, .reset, .regWrite, .regRead, .regAddr,
    .regWriteData, .regReadData, .regReadValid, .intermediateOffsetWord(iow),
    .mixerOffsetWord(mow), .signedSynthOffset(sso), .carrierBaseWord(cbw),
    .synthFrequencyWord(sfw), .bandwidthExponent(bwe), .bandwidthMantissa(bwm),
    .decimationRatio(dec),
    .symbolRateExponent(sre), .symbolRateMantissa(srm), .symbolRateTerm(srt), .rxActive);
  task automatic chk(input logic [23:0] s, input logic [23:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("FAIL %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic rchk(input logic [5:0] a, input logic [7:0] e);
    smc_host_model_i.rd(a, rdat, vld);
    chk(24'(rdat), 24'(e));
    chk(24'(vld), 24'h000001);
  endtask
  task automatic t_reset;
    logic [7:0] rst [7] = '{8'h0F, 8'h00, 8'h1E, 8'hC4, 8'hEC, 8'h8C, 8'h22};
    for (int i = 0; i < 7; i++) rchk(6'h0B + 6'(i), rst[i]);
    chk(cbw, 24'h1EC4EC);
    chk(24'(sre), 24'h00000C);
  endtask
  // Ones everywhere shows which bits are read-only; unmapped places must stay silent.
  task automatic t_access;
    logic [7:0] msk [7] = '{8'h3F, 8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
    for (int i = 0; i < 7; i++) smc_host_model_i.wr(6'h0B + 6'(i), 8'hFF);
    for (int i = 0; i < 7; i++) rchk(6'h0B + 6'(i), msk[i]);
    smc_host_model_i.wr(6'h12, 8'h5A);
    rchk(6'h12, 8'h00);
    rchk(6'h0A, 8'h00);
  endtask
  task automatic t_synth;
    smc_host_model_i.wr(6'h0D, 8'h12);
    smc_host_model_i.wr(6'h0E, 8'h34);
    smc_host_model_i.wr(6'h0F, 8'h56);
    smc_host_model_i.wr(6'h0C, 8'hF0);
    smc_host_model_i.wr(6'h0B, 8'h05);
    rxActive = 1'b0;
    repeat (2) @(negedge mclk);
    chk(cbw, 24'h123456);
    chk(sfw, 24'h123446);
    chk(24'(sso), 24'h0000F0);
    chk(24'(iow), 24'h000005);
    chk(24'(mow), 24'h000005);
    rxActive = 1'b1;
    repeat (2) @(negedge mclk);
    chk(sfw, 24'h123441);
  endtask
  task automatic t_rate(input logic [7:0] r, input logic [23:0] d, input logic [23:0] t);
    smc_host_model_i.wr(6'h10, r);
    smc_host_model_i.wr(6'h11, 8'h80);
    repeat (2) @(negedge mclk);
    chk(24'(dec), d);
    chk(24'(bwe), 24'(r[7:6]));
    chk(24'(bwm), 24'(r[5:4]));
    chk(24'(srm), 24'h000180);
    chk(srt, t);
    chk(24'(sre), 24'(r[3:0]));
  endtask
  task automatic wrap_up;
    if (fails == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // The whole sequence needs well under a thousand cycles, so the ceiling is generous.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      wrap_up;
    end
  end
  initial begin
    repeat (12) @(negedge mclk);
    reset = 1'b0;
    t_reset;
    t_access;
    t_synth;
    t_rate(8'h63, 24'h00000C, 24'h000C00);
    t_rate(8'hF0, 24'h000038, 24'h000180);
    wrap_up;
  end
endmodule
bind smc_config_regs smc_config_regs_asserts smc_config_regs_asserts_i (.mclk, .reset,
  .regRead, .regWrite, .regReadValid, .rxActive, .regAddr, .regReadData, .signedSynthOffset,
  .intermediateOffsetWord, .mixerOffsetWord, .carrierBaseWord, .synthFrequencyWord,
  .symbolRateTerm, .symbolRateExponent, .symbolRateMantissa);
